/* dzx_pkg.sv */
// package: opcodes, field positions, bus map and shared types for the decoder block
package dzx_pkg;
  localparam logic [5:0] OP_DIFF_ZERO_IMM = 6'h09;
  localparam logic [5:0] OP_EXTENDED = 6'h1F;
  localparam logic [9:0] XO_EXT_CTL_IN = 10'h136; // 310
  localparam logic [9:0] XO_EXT_CTL_OUT = 10'h1B6; // 438
  localparam logic [9:0] XO_IO_ORDER = 10'h356; // 854
  localparam logic [9:0] XO_SIGN_EXT_WORD = 10'h3DA; // 986
  localparam int XLEN = 64;
  localparam int WORD_BITS = 32;
  localparam int IMM_BITS = 16;
  // avalon register byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_SRC_A_LO = 8'h04;
  localparam logic [7:0] ADDR_SRC_A_HI = 8'h08;
  localparam logic [7:0] ADDR_SRC_B_LO = 8'h0C;
  localparam logic [7:0] ADDR_SRC_B_HI = 8'h10;
  localparam logic [7:0] ADDR_SRC_S_LO = 8'h14;
  localparam logic [7:0] ADDR_SRC_S_HI = 8'h18;
  localparam logic [7:0] ADDR_EXT_ACC = 8'h1C;
  localparam logic [7:0] ADDR_GO = 8'h20;
  localparam logic [7:0] ADDR_RES_LO = 8'h24;
  localparam logic [7:0] ADDR_RES_HI = 8'h28;
  localparam logic [7:0] ADDR_FLAGS = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
  localparam logic [7:0] ADDR_ORDER_CI = 8'h38;
  localparam int EXT_ACC_EN_BIT = 31;
  localparam int UNIT_ID_BITS = 4;
  localparam int IRQ_BITS = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACCESS = 1;
  localparam int IRQ_ILLEGAL = 2;
  localparam int IRQ_MISALIGN = 3;
  localparam logic [31:0] BUS_UNMAPPED = 32'hDEAD_BEEF;
  typedef struct packed {
    logic valid;
    logic write;
    logic [UNIT_ID_BITS-1:0] unit_id;
    logic [XLEN-1:0] real_addr;
    logic [WORD_BITS-1:0] wdata;
    logic cache_bypass;
    logic prot_store;
  } dzx_ctl_req_type;
  typedef struct packed {
    logic less_than_flag;
    logic greater_flag;
    logic zero_result_flag;
    logic summary_ovf;
  } dzx_cr_type;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_EXEC = 5'b00010,
    ST_DRAIN = 5'b00100,
    ST_REQ = 5'b01000,
    ST_WAIT = 5'b10000
  } dzx_state_type;
endpackage

/* dzx_decoder.sv */
// instruction execution block: difference-or-zero, external control, io ordering, sign extension
// Operation
// - diff-or-zero imm: not base plus imm plus one
// - base greater than imm gives zero
// - diff-or-zero leaves flags untouched
// - control load returns controller word to target
// - address is index alone when base field zero
// - enabled load goes cache-bypassed to unit id
// - enabled store sends address and source word
// - control store sends real address and source
// - control address must be word aligned; a misaligned one is flagged but still sent
// - protection: load as load, store as store
// - barrier drains earlier accesses before later ones
// - barrier orders only cache-inhibited accesses
// - barrier leaves flags untouched
// - word sign extend fills from bit 32
// - record bit updates condition field zero
// - sign extend illegal on 32-bit build

// register map, byte offsets on the avalon side:
//   00 instruction word under test
//   04 / 08 base operand, low and high word
//   0C / 10 index operand, low and high word
//   14 / 18 source operand, low and high word
//   1C access register: bit 31 enable, low bits unit id
//   20 go on write of bit 0, one-hot state on read
//   24 / 28 result, low and high word
//   2C flags: bit 0 summary overflow, bits 4:1 condition field zero
//   30 sticky event status, write one to clear
//   34 event mask, same layout as status
//   38 barrier scope: bit 0 set means cache-inhibited ordering
//   anything else reads back a fixed marker and drops writes
//
// event bits:
//   0 done, set on every return to idle
//   1 access fault, no request leaves the block
//   2 illegal, word sign extend on a 32-bit build
//   3 misaligned, the request still goes out
//
// bus timing:
//   writes never wait; a write while busy is dropped silently, except a status clear,
//   so software must poll go until it reads idle before loading
//   new operands. reads wait exactly one cycle because the read
//   word comes from a flop; that costs a cycle on every read but
//   keeps the readback mux off the bus timing path.
//
// sequencer:
//   idle  waits for go
//   exec  one cycle: arithmetic results land here, and the
//         decision to drain, request or finish is taken
//   drain holds while earlier cache-inhibited traffic is pending
//   req   loads the controller request flops
//   wait  holds the request until the synchronised acknowledge
//
// controller handshake:
//   the request is a registered level, valid until the
//   acknowledge has passed the two sync flops. the returned word
//   is taken without its own sync: the far side must keep it
//   still while acknowledge is high, which is what makes the
//   two-flop delay on acknowledge safe for the data as well.
//   the far side must drop acknowledge before the next request,
//   otherwise a stale high level would end the next wait early.
//
// limitations:
//   byte enables are ignored; every write is a full word.
//   a misaligned control address is reported but still sent,
//   since the outcome at the far side is not ours to define.
//   the summary overflow bit is software-owned here; only word
//   sign extend with the record bit copies it into the flags.
//   the load result is zero-extended to the full register width.
//   on a 32-bit build word sign extend writes no result and no flags, only the illegal and done events.
//
// reset:
//   everything clears except barrier scope, which comes up set
//   so that ordering is the safe default until software says
//   otherwise.
module dzx_decoder
  import dzx_pkg::*;
#(
  parameter bit IS_64BIT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output dzx_ctl_req_type ctl_req,
  input wire logic ctl_ack,
  input wire logic [WORD_BITS-1:0] ctl_rdata,
  input wire logic mem_pending_ci,
  output logic irq
);
  logic [31:0] instr_reg;
  logic [XLEN-1:0] base_gpr_reg, index_gpr_reg, source_gpr_reg, result_reg;
  logic [31:0] external_access_reg;
  logic order_ci_reg;
  dzx_cr_type condition_field_zero_reg;
  logic summary_ovf_reg;
  logic [IRQ_BITS-1:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic go_pulse, rd_ack_reg, busy;
  logic ack_s1_reg, ack_s2_reg, pend_s1_reg, pend_s2_reg;
  dzx_state_type state_reg, state_next;
  dzx_ctl_req_type ctl_req_reg;

  logic [5:0] primary;
  logic [9:0] extended;
  logic base_field_zero, record_bit;
  logic [XLEN-1:0] effective_address, imm_sext, doz_sum, sext_word;
  logic is_doz, is_in, is_out, is_order, is_sext, is_ctl;
  logic [UNIT_ID_BITS-1:0] target_unit_id;

  // instruction fields
  assign primary = instr_reg[31:26];
  assign extended = instr_reg[10:1];
  assign record_bit = instr_reg[0];
  assign base_field_zero = (instr_reg[20:16] == 5'h00);
  assign is_doz = (primary == OP_DIFF_ZERO_IMM);
  assign is_in = (primary == OP_EXTENDED) && (extended == XO_EXT_CTL_IN);
  assign is_out = (primary == OP_EXTENDED) && (extended == XO_EXT_CTL_OUT);
  assign is_order = (primary == OP_EXTENDED) && (extended == XO_IO_ORDER);
  assign is_sext = (primary == OP_EXTENDED) && (extended == XO_SIGN_EXT_WORD);
  assign is_ctl = is_in | is_out;
  assign target_unit_id = external_access_reg[UNIT_ID_BITS-1:0];

  // index alone when base field is zero
  assign effective_address = base_field_zero ? index_gpr_reg
                           : base_gpr_reg + index_gpr_reg;
  assign imm_sext = {{(XLEN-IMM_BITS){instr_reg[IMM_BITS-1]}}, instr_reg[IMM_BITS-1:0]};
  assign doz_sum = ~base_gpr_reg + imm_sext + {{(XLEN-1){1'b0}}, 1'b1};
  assign sext_word = {{(XLEN-WORD_BITS){source_gpr_reg[WORD_BITS-1]}},
                      source_gpr_reg[WORD_BITS-1:0]};

  // pin-level acknowledge and pending inputs from the controller and memory system are synchronised
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      pend_s1_reg <= 1'b0;
      pend_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ctl_ack;
      ack_s2_reg <= ack_s1_reg;
      pend_s1_reg <= mem_pending_ci;
      pend_s2_reg <= pend_s1_reg;
    end
  end

  assign busy = (state_reg != ST_IDLE);
  assign go_pulse = avs_write && (avs_address == ADDR_GO) && avs_writedata[0] && !busy;

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go_pulse) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_order && order_ci_reg) begin
          state_next = ST_DRAIN;
        end else if (is_ctl && external_access_reg[EXT_ACC_EN_BIT]) begin
          state_next = pend_s2_reg ? ST_DRAIN : ST_REQ;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        // earlier cache-inhibited accesses must finish first
        if (!pend_s2_reg) begin
          state_next = (is_ctl && external_access_reg[EXT_ACC_EN_BIT]) ? ST_REQ : ST_IDLE;
        end
      end
      ST_REQ: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (ack_s2_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // controller request held until the synchronised acknowledge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_req_reg <= '0;
    end else if (state_reg == ST_REQ) begin
      ctl_req_reg.valid <= 1'b1;
      ctl_req_reg.write <= is_out;
      ctl_req_reg.unit_id <= target_unit_id;
      ctl_req_reg.real_addr <= effective_address;
      ctl_req_reg.wdata <= source_gpr_reg[WORD_BITS-1:0];
      ctl_req_reg.cache_bypass <= 1'b1;
      ctl_req_reg.prot_store <= is_out;
    end else if (state_reg == ST_WAIT && ack_s2_reg) begin
      ctl_req_reg <= '0;
    end
  end
  assign ctl_req = ctl_req_reg;

  // result register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_reg <= '0;
    end else if (state_reg == ST_EXEC && is_doz) begin
      // signed compare of base against the immediate
      result_reg <= ($signed(base_gpr_reg) > $signed(imm_sext)) ? '0 : doz_sum;
    end else if (state_reg == ST_EXEC && is_sext && IS_64BIT) begin
      result_reg <= sext_word;
    end else if (state_reg == ST_WAIT && ack_s2_reg && is_in) begin
      result_reg <= {{(XLEN-WORD_BITS){1'b0}}, ctl_rdata};
    end
  end

  // condition field zero: only word sign extend with record bit writes it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      condition_field_zero_reg <= '0;
    end else if (state_reg == ST_EXEC && is_sext && IS_64BIT && record_bit) begin
      condition_field_zero_reg.less_than_flag <= sext_word[XLEN-1];
      condition_field_zero_reg.greater_flag <= !sext_word[XLEN-1] && (sext_word != '0);
      condition_field_zero_reg.zero_result_flag <= (sext_word == '0);
      condition_field_zero_reg.summary_ovf <= summary_ovf_reg;
    end
  end

  // interrupt events: done, access fault, illegal, misaligned
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE] = (state_reg != ST_IDLE) && (state_next == ST_IDLE);
    irq_set[IRQ_ACCESS] = (state_reg == ST_EXEC) && is_ctl
                          && !external_access_reg[EXT_ACC_EN_BIT];
    irq_set[IRQ_ILLEGAL] = (state_reg == ST_EXEC) && is_sext && !IS_64BIT;
    irq_set[IRQ_MISALIGN] = (state_reg == ST_EXEC) && is_ctl
                            && (effective_address[1:0] != 2'b00);
  end

  // write-one clear strobe for the status register; not gated by busy
  logic stat_clr_hit;
  assign stat_clr_hit = avs_write && (avs_address == ADDR_IRQ_STAT);

  // sticky status, one flop per event; a new event wins over a clear
  // so that an event landing in the clear cycle is never lost
  for (genvar g = 0; g < IRQ_BITS; g++) begin : g_stat
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        irq_stat_reg[g] <= 1'b0;
      end else if (irq_set[g]) begin
        irq_stat_reg[g] <= 1'b1;
      end else if (stat_clr_hit && avs_writedata[g]) begin
        irq_stat_reg[g] <= 1'b0;
      end
    end
  end

  // level interrupt while any unmasked event is pending
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // software writable registers; operands are frozen while busy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instr_reg <= '0;
      base_gpr_reg <= '0;
      index_gpr_reg <= '0;
      source_gpr_reg <= '0;
      external_access_reg <= '0;
      irq_mask_reg <= '0;
      order_ci_reg <= 1'b1;
      summary_ovf_reg <= 1'b0;
    end else if (avs_write && !busy) begin
      case (avs_address)
        ADDR_INSTR: instr_reg <= avs_writedata;
        ADDR_SRC_A_LO: base_gpr_reg[31:0] <= avs_writedata;
        ADDR_SRC_A_HI: base_gpr_reg[63:32] <= avs_writedata;
        ADDR_SRC_B_LO: index_gpr_reg[31:0] <= avs_writedata;
        ADDR_SRC_B_HI: index_gpr_reg[63:32] <= avs_writedata;
        ADDR_SRC_S_LO: source_gpr_reg[31:0] <= avs_writedata;
        ADDR_SRC_S_HI: source_gpr_reg[63:32] <= avs_writedata;
        ADDR_EXT_ACC: external_access_reg <= avs_writedata;
        ADDR_IRQ_MASK: irq_mask_reg <= avs_writedata[IRQ_BITS-1:0];
        ADDR_ORDER_CI: order_ci_reg <= avs_writedata[0];
        ADDR_FLAGS: summary_ovf_reg <= avs_writedata[0];
        default: ;
      endcase
    end
  end

  // writes answer at once (ignored while busy, except status clears); reads take one wait cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_ack_reg <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rd_ack_reg <= avs_read && !rd_ack_reg;
      if (avs_read && !rd_ack_reg) begin
        case (avs_address)
          ADDR_INSTR: avs_readdata <= instr_reg;
          ADDR_SRC_A_LO: avs_readdata <= base_gpr_reg[31:0];
          ADDR_SRC_A_HI: avs_readdata <= base_gpr_reg[63:32];
          ADDR_SRC_B_LO: avs_readdata <= index_gpr_reg[31:0];
          ADDR_SRC_B_HI: avs_readdata <= index_gpr_reg[63:32];
          ADDR_SRC_S_LO: avs_readdata <= source_gpr_reg[31:0];
          ADDR_SRC_S_HI: avs_readdata <= source_gpr_reg[63:32];
          ADDR_EXT_ACC: avs_readdata <= external_access_reg;
          ADDR_GO: avs_readdata <= {27'h0000000, state_reg};
          ADDR_RES_LO: avs_readdata <= result_reg[31:0];
          ADDR_RES_HI: avs_readdata <= result_reg[63:32];
          ADDR_FLAGS: avs_readdata <= {27'h0000000, condition_field_zero_reg, summary_ovf_reg};
          ADDR_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_reg};
          ADDR_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask_reg};
          ADDR_ORDER_CI: avs_readdata <= {31'h00000000, order_ci_reg};
          default: avs_readdata <= BUS_UNMAPPED;
        endcase
      end
    end
  end
  assign avs_waitrequest = avs_read && !rd_ack_reg;
endmodule

/* dzx_decoder_sva.sv */
// port checker for the decoder block
module dzx_decoder_sva
  import dzx_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire dzx_ctl_req_type ctl_req,
  input wire logic ctl_ack,
  input wire logic mem_pending_ci
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // bus timing as promised in the hand-over
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait is not one cycle");
  // request shape and handshake on the controller side
  a_req_bypass: assert property (ctl_req.valid |-> ctl_req.cache_bypass)
    else $error("request not cache bypassed");
  a_prot_kind: assert property (ctl_req.valid |-> ctl_req.prot_store == ctl_req.write)
    else $error("protection kind wrong");
  a_req_stable: assert property (
    ctl_req.valid && $past(ctl_req.valid) |-> $stable(ctl_req))
    else $error("request changed while pending");
  a_drop_after_ack: assert property ($fell(ctl_req.valid) |-> $past(ctl_ack))
    else $error("request dropped without ack");
  a_release_bound: assert property ($rose(ctl_ack) |-> ##[1:5] !ctl_req.valid)
    else $error("request held too long after ack");
  // pending passes two sync flops, then REQ costs one edge and valid shows one later
  a_barrier_wait: assert property ($rose(ctl_req.valid) |-> !$past(mem_pending_ci, 4))
    else $error("request passed pending traffic");
  c_store: cover property ($rose(ctl_req.valid) && ctl_req.write);
  c_load: cover property ($rose(ctl_req.valid) && !ctl_req.write);
  c_drain: cover property ($fell(mem_pending_ci));
endmodule

bind dzx_decoder dzx_decoder_sva i_sva (.clk, .nrst, .avs_read, .avs_write, .avs_waitrequest,
  .ctl_req, .ctl_ack, .mem_pending_ci);

/* dzx_ctl_model.sv */
// far-side controller model for the external control port
module dzx_ctl_model
  import dzx_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire dzx_ctl_req_type ctl_req,
  input wire logic [3:0] delay,
  input wire logic [WORD_BITS-1:0] load_word,
  output logic ctl_ack,
  output logic [WORD_BITS-1:0] ctl_rdata,
  output dzx_ctl_req_type last_req,
  output logic [7:0] n_req
);
  logic [3:0] wait_cnt;
  // answer delay+1 cycles after valid is first seen; the word is only valid while ack is up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_ack <= 1'b0;
      ctl_rdata <= 32'h0;
      wait_cnt <= 4'h0;
      last_req <= '0;
      n_req <= 8'h00;
    end else if (ctl_req.valid && !ctl_ack) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == delay) begin
        ctl_ack <= 1'b1;
        ctl_rdata <= load_word;
        last_req <= ctl_req;
        n_req <= n_req + 8'h01;
      end
    end else if (!ctl_req.valid && ctl_ack) begin
      ctl_ack <= 1'b0;
      wait_cnt <= 4'h0;
      ctl_rdata <= ~ctl_rdata; // released word must not look valid
    end
  end
endmodule

/* dzx_decoder_bench.sv */
// self-checking bench for the decoder block
module dzx_decoder_bench
  import dzx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] ins;
    logic [63:0] src;
    logic [63:0] res;
    logic [31:0] flg;
  } dzx_row_type;
  // operand feeds A and S alike; each opcode reads only its own source
  dzx_row_type tbl [9] = '{
    '{32'h7C8307B4, 64'h0000_0000_8000_0001, 64'hFFFF_FFFF_8000_0001, 32'h00},
    '{32'h7C8307B5, 64'hFFFF_FFFF_7FFF_FFFF, 64'h0000_0000_7FFF_FFFF, 32'h08},
    '{32'h7C8307B5, 64'h1234_5678_0000_0000, 64'h0, 32'h04},
    '{32'h7C8307B5, 64'h0000_0000_8000_0000, 64'hFFFF_FFFF_8000_0000, 32'h10},
    '{32'h24640000, 64'h1, 64'h0, 32'h10},
    '{32'h24640008, 64'h2, 64'h6, 32'h10},
    '{32'h2464FFFF, 64'hFFFF_FFFF_FFFF_FFFB, 64'h4, 32'h10},
    '{32'h24648000, 64'h0, 64'h0, 32'h10},
    '{32'h24647FFF, 64'h8000_0000_0000_0000, 64'h8000_0000_0000_7FFF, 32'h10}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  dzx_ctl_req_type ctl_req;
  dzx_ctl_req_type last_req;
  logic ctl_ack;
  logic [31:0] ctl_rdata;
  logic mem_pending_ci = 1'b0;
  logic irq;
  logic irq32;
  logic [3:0] delay = 4'h3;
  logic [7:0] n_req;
  logic [31:0] rd;
  int n_errors = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  dzx_decoder i_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .ctl_req, .ctl_ack,
    .ctl_rdata, .mem_pending_ci, .irq);
  // a 32-bit build on the same bus; its controller never answers
  dzx_decoder #(.IS_64BIT(1'b0)) i_dut32 (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata(), .avs_waitrequest(), .ctl_req(),
    .ctl_ack(1'b0), .ctl_rdata(32'h0), .mem_pending_ci, .irq(irq32));
  dzx_ctl_model i_ctl (.clk, .nrst, .ctl_req, .delay, .load_word(32'hCAFE_F00D), .ctl_ack,
    .ctl_rdata, .last_req, .n_req);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // an idle edge before each request keeps strobes from being set twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rdb(input logic [7:0] a);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rdb(a);
    chk(rd, exp);
  endtask
  // irq is combinational from registers; look once the edge has settled
  task automatic ichk(input logic exp);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic run(input logic [31:0] ins, input logic [63:0] a, b, s);
    wr(ADDR_INSTR, ins);
    wr(ADDR_SRC_A_LO, a[31:0]);
    wr(ADDR_SRC_A_HI, a[63:32]);
    wr(ADDR_SRC_B_LO, b[31:0]);
    wr(ADDR_SRC_B_HI, b[63:32]);
    wr(ADDR_SRC_S_LO, s[31:0]);
    wr(ADDR_SRC_S_HI, s[63:32]);
    wr(ADDR_GO, 32'h1);
  endtask
  task automatic wait_idle();
    rd = 32'h0;
    for (int i = 0; i < 40 && rd !== 32'h1; i++) rdb(ADDR_GO);
    chk(rd, 32'h1);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(ADDR_ORDER_CI, 32'h1);
    rchk(ADDR_IRQ_MASK, 32'h0);
    rchk(8'h3C, BUS_UNMAPPED);
    foreach (tbl[i]) begin
      run(tbl[i].ins, tbl[i].src, 64'h0, tbl[i].src);
      wait_idle();
      rchk(ADDR_RES_LO, tbl[i].res[31:0]);
      rchk(ADDR_RES_HI, tbl[i].res[63:32]);
      rchk(ADDR_FLAGS, tbl[i].flg);
    end
    // the 32-bit build flags word sign extend as illegal, the 64-bit one never
    wr(ADDR_IRQ_MASK, 32'h4);
    @(negedge clk);
    chk({31'h0, irq32}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
    // sticky done stays hidden until unmasked, then clears by writing one
    rchk(ADDR_IRQ_STAT, 32'h1);
    ichk(1'b0);
    wr(ADDR_IRQ_MASK, 32'h1);
    ichk(1'b1);
    wr(ADDR_IRQ_STAT, 32'h1);
    ichk(1'b0);
    // slow load with a base register, then a prompt store with base field zero
    wr(ADDR_EXT_ACC, 32'h8000_0005);
    run(32'h7C642A6C, 64'h1000, 64'h24, 64'h0);
    wait_idle();
    rchk(ADDR_RES_LO, 32'hCAFE_F00D);
    rchk(ADDR_RES_HI, 32'h0);
    chk(last_req.real_addr[31:0], 32'h1024);
    chk({27'h0, last_req.write, last_req.unit_id}, 32'h5);
    delay <= 4'h0;
    run(32'h7C602B6C, 64'h999, 64'h2000, 64'h1357_9BDF);
    wait_idle();
    chk(last_req.real_addr[31:0], 32'h2000);
    chk(last_req.wdata, 32'h1357_9BDF);
    chk({27'h0, last_req.write, last_req.unit_id}, 32'h15);
    // misaligned address still goes out but is flagged
    run(32'h7C642A6C, 64'h1000, 64'h26, 64'h0);
    wait_idle();
    chk({24'h0, n_req}, 32'h3);
    rchk(ADDR_IRQ_STAT, 32'h9);
    // access disabled: nothing reaches the controller, fault raised
    wr(ADDR_IRQ_STAT, 32'hF);
    wr(ADDR_IRQ_MASK, 32'h2);
    wr(ADDR_EXT_ACC, 32'h0000_0005);
    run(32'h7C642A6C, 64'h1000, 64'h24, 64'h0);
    wait_idle();
    chk({24'h0, n_req}, 32'h3);
    ichk(1'b1);
    wr(ADDR_IRQ_STAT, 32'h2);
    ichk(1'b0);
    // barrier then load, each held back by pending cache-inhibited traffic
    wr(ADDR_EXT_ACC, 32'h8000_0005);
    for (int k = 0; k < 2; k++) begin
      mem_pending_ci <= 1'b1;
      run(k ? 32'h7C642A6C : 32'h7C0006AC, 64'h1000, 64'h24, 64'h0);
      repeat (8) @(posedge clk);
      rdb(ADDR_GO);
      chk({31'h0, rd == 32'h1}, 32'h0);
      chk({24'h0, n_req}, 32'h3);
      mem_pending_ci <= 1'b0;
      wait_idle();
    end
    chk({24'h0, n_req}, 32'h4);
    rchk(ADDR_FLAGS, 32'h10);
    // barrier outside cache-inhibited space does not wait
    wr(ADDR_ORDER_CI, 32'h0);
    mem_pending_ci <= 1'b1;
    run(32'h7C0006AC, 64'h0, 64'h0, 64'h0);
    wait_idle();
    // reset in mid-run drops a held barrier and restores defaults
    wr(ADDR_ORDER_CI, 32'h1);
    run(32'h7C0006AC, 64'h0, 64'h0, 64'h0);
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(ADDR_GO, 32'h1);
    rchk(ADDR_ORDER_CI, 32'h1);
    end_of_test();
  end
  // the sequence needs several hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule
